// ---- include/lssc_params.svh ----
// Purpose: offsets, field positions, reset values and timing for the link status and slot caps block
// Assumes: 32-bit dword configuration access at byte offsets
// Notes:   definitions only
`ifndef LSSC_PARAMS_SVH
`define LSSC_PARAMS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define LSSC_OFF_LINK            8'hD0
`define LSSC_OFF_SLOTCAP         8'hD4

// ----------------------------------------
// link control / status fields
// ----------------------------------------
`define LSSC_RETRAIN_BIT         5
`define LSSC_SPD_LSB             16
`define LSSC_SPD_MSB             19
`define LSSC_WID_LSB             20
`define LSSC_WID_MSB             25
`define LSSC_TRERR_BIT           26
`define LSSC_TRAIN_BIT           27
`define LSSC_SCLK_BIT            28
`define LSSC_DLACT_BIT           29
`define LSSC_BWMG_BIT            30
`define LSSC_ABW_BIT             31
`define LSSC_SPD_RST             4'h2
`define LSSC_SPD_2G5             4'h1
`define LSSC_SPD_5G0             4'h2
`define LSSC_WID_RST             6'h01

// ----------------------------------------
// slot capability fields
// ----------------------------------------
`define LSSC_FLAGS_LSB           0
`define LSSC_FLAGS_MSB           6
`define LSSC_PLV_LSB             7
`define LSSC_PLV_MSB             14
`define LSSC_PLS_LSB             15
`define LSSC_PLS_MSB             16
`define LSSC_PSN_LSB             19
`define LSSC_PSN_MSB             31
`define LSSC_FLAGS_RST           7'h5F
`define LSSC_PLV_RST             8'h19
`define LSSC_PLS_RST             2'h0
`define LSSC_PSN_RST             13'h0000
`define LSSC_SCLK_RST            1'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define LSSC_CLK_NS              10
`define LSSC_MSG_HOLD_NS         20
`define LSSC_MSG_HOLD_CYC        ((`LSSC_MSG_HOLD_NS + `LSSC_CLK_NS - 1) / `LSSC_CLK_NS)

`endif

// ---- include/lssc_pkg.sv ----
// Purpose: shared types of the link status and slot caps block
// Assumes: nothing
// Notes:   constants live in lssc_params.svh
package lssc_pkg;
  typedef enum logic [2:0] {
    LSSC_MSG_IDLE = 3'b001,
    LSSC_MSG_REQ  = 3'b010,
    LSSC_MSG_HOLD = 3'b100
  } lssc_msg_e;
  typedef logic [31:0] lssc_word_t;
endpackage : lssc_pkg

// ---- include/lssc_msg_if.sv ----
// Purpose: carries a slot power limit message request between the register file and sender
// Assumes: single clock
// Notes:   none
interface lssc_msg_if;
  logic       req;
  logic [7:0] value;
  logic [1:0] scale;
  logic       busy;
  modport regs (output req, output value, output scale, input busy);
  modport send (input req, input value, input scale, output busy);
endinterface : lssc_msg_if

// ---- design/lssc_msg_send.sv ----
// Purpose: emits the slot power limit message toward the link layer
// Assumes: link layer accepts on o_msg_valid & i_msg_ready
// Notes:   a write during a pending send updates the payload once more afterwards
`include "lssc_params.svh"
module lssc_msg_send (
  input  wire logic    i_sys_clk,
  input  wire logic    i_sys_rst,
  lssc_msg_if.send     bus,
  input  wire logic    i_msg_ready,
  output logic         o_msg_valid,
  output logic [9:0]   o_msg_payload
);
  lssc_pkg::lssc_msg_e st_r;
  logic                pend_r;

  // ----------------------------------------
  // message sequencer
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r          <= lssc_pkg::LSSC_MSG_IDLE;
      pend_r        <= 1'b0;
      o_msg_valid   <= 1'b0;
      o_msg_payload <= 10'h000;
    end else begin
      if (bus.req && st_r != lssc_pkg::LSSC_MSG_IDLE) begin
        pend_r <= 1'b1;
      end
      case (st_r)
        lssc_pkg::LSSC_MSG_IDLE: begin
          if (bus.req || pend_r) begin
            st_r          <= lssc_pkg::LSSC_MSG_REQ;
            pend_r        <= 1'b0;
            o_msg_valid   <= 1'b1;
            o_msg_payload <= {bus.scale, bus.value};
          end
        end
        lssc_pkg::LSSC_MSG_REQ: begin
          if (i_msg_ready) begin
            st_r        <= lssc_pkg::LSSC_MSG_HOLD;
            o_msg_valid <= 1'b0;
          end
        end
        lssc_pkg::LSSC_MSG_HOLD: begin
          st_r <= lssc_pkg::LSSC_MSG_IDLE;
        end
        default: begin
          st_r <= lssc_pkg::LSSC_MSG_IDLE;
        end
      endcase
    end
  end

  assign bus.busy = (st_r != lssc_pkg::LSSC_MSG_IDLE);

  AST_MSG_HELD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_msg_valid && !i_msg_ready |=> o_msg_valid && $stable(o_msg_payload))
    else $error("message dropped before acceptance");
endmodule : lssc_msg_send

// ---- design/lssc_regs.sv ----
// Purpose: per-port link status and slot capability registers
// Assumes: config dword access, one cycle read latency, byte enables per lane
// Notes:   slot capability reads zero on the upstream port
`include "lssc_params.svh"
// Operation
// - Link speed field 19:16 reports negotiated rate, resets to 5.0 Gb/s code.
// - Lane count field 25:20 reports negotiated width, resets to x1.
// - Bit 26 sets on training failure, clears on successful L0 training.
// - Bit 27 high while training runs, cleared when done, resets one.
// - Bit 28 shows slot reference clock use, resets to one.
// - Bit 29 is one while data link is active, registered one cycle after it.
// - Slot capability bits 0 to 4 advertise slot features, reset to one.
// - Bit 5 advertises surprise removal, resets to zero.
// - Bit 6 advertises hot-plug capability, resets to one.
// - Writable power limit value at 14:7, resets to 19h.
// - Writable power limit scale at 16:15, resets to 00b.
// - Writing either power limit field sends a slot power limit message, except in a cycle with an external load.
// - Read-only physical slot number at 31:19, resets to zero.
// - Capability defaults and slot clock bit can be loaded externally.
// - Slot capability applies to downstream ports only.
// - Retrain bit starts retraining on downstream ports, always reads zero.
module lssc_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_downstream,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_rvalid,
  input  wire logic [3:0]  i_link_speed,
  input  wire logic [5:0]  i_link_width,
  input  wire logic        i_train_fail,
  input  wire logic        i_train_start,
  input  wire logic        i_train_done_l0,
  input  wire logic        i_dl_active,
  input  wire logic        i_bw_mgmt_evt,
  input  wire logic        i_auto_bw_evt,
  input  wire logic        i_ld_valid,
  input  wire logic [31:0] i_ld_slotcap,
  input  wire logic        i_ld_slot_clk,
  output logic             o_retrain,
  input  wire logic        i_msg_ready,
  output logic             o_msg_valid,
  output logic [9:0]       o_msg_payload
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [3:0]  spd_r;
  logic [5:0]  wid_r;
  logic        trerr_r;
  logic        train_r;
  logic        sclk_r;
  logic        dlact_r;
  logic        bwmg_r;
  logic        abw_r;
  logic [6:0]  flags_r;
  logic [7:0]  plv_r;
  logic [1:0]  pls_r;
  logic [12:0] psn_r;
  logic        msg_req_r;
  logic        wr_link;
  logic        wr_cap;
  logic        pl_wr;
  lssc_pkg::lssc_word_t link_word;
  lssc_pkg::lssc_word_t cap_word;

  lssc_msg_if msg ();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_link = i_cfg_wr && hit(i_cfg_addr, `LSSC_OFF_LINK);
  assign wr_cap  = i_cfg_wr && hit(i_cfg_addr, `LSSC_OFF_SLOTCAP) && i_downstream;
  // value spans lanes 0/1, scale lane 1/2
  assign pl_wr   = wr_cap && (|i_cfg_be[2:0]);

  // ----------------------------------------
  // link status tracking
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      spd_r   <= `LSSC_SPD_RST;
      wid_r   <= `LSSC_WID_RST;
      dlact_r <= 1'b0;
    end else begin
      spd_r   <= i_link_speed;
      wid_r   <= i_link_width;
      dlact_r <= i_dl_active;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      trerr_r <= 1'b0;
      train_r <= 1'b1;
    end else begin
      if (i_train_fail) begin
        trerr_r <= 1'b1;
      end else if (i_train_done_l0) begin
        trerr_r <= 1'b0;
      end
      if (i_train_start || o_retrain) begin
        train_r <= 1'b1;
      end else if (i_train_done_l0 || i_train_fail) begin
        train_r <= 1'b0;
      end
    end
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bwmg_r <= 1'b0;
      abw_r  <= 1'b0;
    end else begin
      if (i_bw_mgmt_evt) begin
        bwmg_r <= 1'b1;
      end else if (wr_link && i_cfg_be[3] && i_cfg_wdata[`LSSC_BWMG_BIT]) begin
        bwmg_r <= 1'b0;
      end
      if (i_auto_bw_evt) begin
        abw_r <= 1'b1;
      end else if (wr_link && i_cfg_be[3] && i_cfg_wdata[`LSSC_ABW_BIT]) begin
        abw_r <= 1'b0;
      end
    end
  end

  // retrain is a self-clearing strobe, never stored as readable state
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_retrain <= 1'b0;
    end else begin
      o_retrain <= wr_link && i_downstream && i_cfg_be[0]
                   && i_cfg_wdata[`LSSC_RETRAIN_BIT];
    end
  end

  // ----------------------------------------
  // slot capabilities
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flags_r <= `LSSC_FLAGS_RST;
      psn_r   <= `LSSC_PSN_RST;
      sclk_r  <= `LSSC_SCLK_RST;
    end else if (i_ld_valid) begin
      flags_r <= i_ld_slotcap[`LSSC_FLAGS_MSB:`LSSC_FLAGS_LSB];
      psn_r   <= i_ld_slotcap[`LSSC_PSN_MSB:`LSSC_PSN_LSB];
      sclk_r  <= i_ld_slot_clk;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      plv_r <= `LSSC_PLV_RST;
      pls_r <= `LSSC_PLS_RST;
    end else if (i_ld_valid) begin
      plv_r <= i_ld_slotcap[`LSSC_PLV_MSB:`LSSC_PLV_LSB];
      pls_r <= i_ld_slotcap[`LSSC_PLS_MSB:`LSSC_PLS_LSB];
    end else if (wr_cap) begin
      if (i_cfg_be[0]) begin
        plv_r[0] <= i_cfg_wdata[7];
      end
      if (i_cfg_be[1]) begin
        plv_r[7:1] <= i_cfg_wdata[14:8];
        pls_r[0]   <= i_cfg_wdata[15];
      end
      if (i_cfg_be[2]) begin
        pls_r[1] <= i_cfg_wdata[16];
      end
    end
  end

  // request follows one cycle later, so the message carries the freshly written value
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      msg_req_r <= 1'b0;
    end else begin
      msg_req_r <= pl_wr && !i_ld_valid;
    end
  end

  assign msg.req   = msg_req_r;
  assign msg.value = plv_r;
  assign msg.scale = pls_r;

  lssc_msg_send u_send (
    .i_sys_clk     (i_sys_clk),
    .i_sys_rst     (i_sys_rst),
    .bus           (msg),
    .i_msg_ready   (i_msg_ready),
    .o_msg_valid   (o_msg_valid),
    .o_msg_payload (o_msg_payload)
  );

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    link_word = 32'h0000_0000;
    link_word[`LSSC_SPD_MSB:`LSSC_SPD_LSB] = spd_r;
    link_word[`LSSC_WID_MSB:`LSSC_WID_LSB] = wid_r;
    link_word[`LSSC_TRERR_BIT] = trerr_r;
    link_word[`LSSC_TRAIN_BIT] = train_r;
    link_word[`LSSC_SCLK_BIT]  = sclk_r;
    link_word[`LSSC_DLACT_BIT] = dlact_r;
    link_word[`LSSC_BWMG_BIT]  = bwmg_r;
    link_word[`LSSC_ABW_BIT]   = abw_r;
  end

  always_comb begin
    cap_word = 32'h0000_0000;
    if (i_downstream) begin
      cap_word[`LSSC_FLAGS_MSB:`LSSC_FLAGS_LSB] = flags_r;
      cap_word[`LSSC_PLV_MSB:`LSSC_PLV_LSB]     = plv_r;
      cap_word[`LSSC_PLS_MSB:`LSSC_PLS_LSB]     = pls_r;
      cap_word[`LSSC_PSN_MSB:`LSSC_PSN_LSB]     = psn_r;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cfg_rdata  <= 32'h0000_0000;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_rd;
      if (!i_cfg_rd) begin
        o_cfg_rdata <= 32'h0000_0000;
      end else if (hit(i_cfg_addr, `LSSC_OFF_LINK)) begin
        o_cfg_rdata <= link_word;
      end else if (hit(i_cfg_addr, `LSSC_OFF_SLOTCAP)) begin
        o_cfg_rdata <= cap_word;
      end else begin
        o_cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_SPEED_TRACK: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    1'b1 |=> spd_r == $past(i_link_speed))
    else $error("link speed not tracked");
  AST_WIDTH_READ: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_cfg_rd && hit(i_cfg_addr, `LSSC_OFF_LINK) |=> o_cfg_rvalid
    && o_cfg_rdata[`LSSC_WID_MSB:`LSSC_WID_LSB] == $past(wid_r))
    else $error("width field misread");
  AST_TRERR_SET: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_train_fail |=> trerr_r)
    else $error("training error not recorded");
  AST_TRERR_CLR: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_train_done_l0 && !i_train_fail |=> !trerr_r)
    else $error("training error not cleared in L0");
  AST_TRAIN_RETRAIN: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_retrain |=> train_r)
    else $error("training bit not raised by retrain");
  AST_TRAIN_DONE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_train_done_l0 && !i_train_start && !o_retrain |=> !train_r)
    else $error("training bit not cleared when done");
  AST_DLACT: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    1'b1 |=> dlact_r == $past(i_dl_active))
    else $error("link active bit not following");
  AST_W1C_SET_WINS: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_bw_mgmt_evt |=> bwmg_r)
    else $error("bandwidth event lost");
  AST_W1C_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    wr_link && i_cfg_be[3] && i_cfg_wdata[`LSSC_ABW_BIT] && !i_auto_bw_evt |=> !abw_r)
    else $error("autonomous bandwidth flag not cleared");
  AST_W1C_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    bwmg_r && !(wr_link && i_cfg_be[3] && i_cfg_wdata[`LSSC_BWMG_BIT]) |=> bwmg_r)
    else $error("bandwidth flag lost without a write of one");
  AST_CAPS_RO: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !i_ld_valid |=> $stable(flags_r) && $stable(psn_r) && $stable(sclk_r))
    else $error("read-only capability field moved");
  AST_LOAD_WINS: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_ld_valid |=> plv_r == $past(i_ld_slotcap[`LSSC_PLV_MSB:`LSSC_PLV_LSB]))
    else $error("loaded power limit value lost");
  AST_MSG_ON_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    pl_wr && !i_ld_valid && !msg.busy && !msg_req_r && !$past(msg.busy)
    |=> ##1 o_msg_valid && o_msg_payload == {pls_r, plv_r})
    else $error("power limit write sent no message");
  AST_UPSTREAM_CAP: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_cfg_rd && hit(i_cfg_addr, `LSSC_OFF_SLOTCAP) && !i_downstream
    |=> o_cfg_rdata == 32'h0000_0000)
    else $error("slot caps visible upstream");
  AST_UP_NO_MSG: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !i_downstream |=> !msg_req_r)
    else $error("power limit message requested upstream");
  AST_RETRAIN_RD0: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_cfg_rvalid && $past(hit(i_cfg_addr, `LSSC_OFF_LINK)) |-> !o_cfg_rdata[`LSSC_RETRAIN_BIT])
    else $error("retrain bit read back nonzero");
  AST_UP_NO_RETRAIN: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !i_downstream |=> !o_retrain)
    else $error("retrain strobe on upstream port");
endmodule : lssc_regs

// ---- tb/lssc_link_model.sv ----
// Purpose: link layer stand-in that takes slot power limit messages
// Assumes: valid/ready handshake, valid held until ready
// Notes:   ready rises only after a programmable wait, to stall the sender
module lssc_link_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_msg_valid,
  input  wire logic [9:0] i_msg_payload,
  input  wire logic [3:0] i_delay,
  output logic            o_msg_ready,
  output int              o_count,
  output logic [9:0]      o_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  // ----------------------------------------
  // acceptance
  // ----------------------------------------
  // ready drops after each take, so every message waits its full delay
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_msg_ready <= 1'b0;
      wait_r      <= 4'h0;
      o_count     <= 0;
      o_last      <= 10'h000;
    end else if (i_msg_valid && o_msg_ready) begin
      o_count     <= o_count + 1;
      o_last      <= i_msg_payload;
      o_msg_ready <= 1'b0;
      wait_r      <= 4'h0;
    end else if (i_msg_valid) begin
      o_msg_ready <= (wait_r >= i_delay);
      wait_r      <= wait_r + 4'h1;
    end
  end
endmodule : lssc_link_model

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the link status and slot caps registers
// Assumes: one cycle read latency, writes take effect next edge
// Notes:   loaded capability image is read back at once
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        sys_clk, sys_rst = 1'b1, downstream = 1'b1;
  logic        cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [3:0]  cfg_be = 4'h0, link_speed = 4'h2, model_delay = 4'h1;
  logic [31:0] cfg_wdata = 32'h0000_0000, rdata, rd;
  logic [5:0]  link_width = 6'h01, ev = 6'h00;
  logic        dl_active = 1'b0, rvalid, retrain, msg_valid, msg_ready;
  logic [9:0]  payload, last;
  int          fail_count = 0, check_count = 0, msg_count;
  typedef struct {logic [3:0] spd; logic [5:0] wid; logic dl;} lssc_row_s;
  lssc_row_s rows [4] = '{'{4'h1, 6'h01, 1'b0}, '{4'h2, 6'h02, 1'b1},
                          '{4'h1, 6'h04, 1'b1}, '{4'h2, 6'h08, 1'b0}};

  lssc_regs i_lssc_regs (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_downstream(downstream),
    .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd), .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be),
    .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
    .i_link_speed(link_speed), .i_link_width(link_width), .i_train_fail(ev[0]),
    .i_train_start(ev[1]), .i_train_done_l0(ev[2]), .i_dl_active(dl_active),
    .i_bw_mgmt_evt(ev[3]), .i_auto_bw_evt(ev[4]), .i_ld_valid(ev[5]),
    .i_ld_slotcap(32'h55E0_99AA), .i_ld_slot_clk(1'b0), .o_retrain(retrain),
    .i_msg_ready(msg_ready), .o_msg_valid(msg_valid), .o_msg_payload(payload));
  lssc_link_model i_lssc_link_model (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
    .i_msg_valid(msg_valid), .i_msg_payload(payload), .i_delay(model_delay),
    .o_msg_ready(msg_ready), .o_count(msg_count), .o_last(last));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic do_reset(input logic ds);
    @(posedge sys_clk);
    sys_rst    <= 1'b1;
    downstream <= ds;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask : do_reset
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge sys_clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask : cfg_write
  task automatic cfg_read(input logic [7:0] a);
    @(posedge sys_clk);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    check("rvalid", 32'h1, {31'h0, rvalid});
    rd = rdata;
  endtask : cfg_read
  task automatic evt(input int k);
    @(posedge sys_clk);
    ev[k] <= 1'b1;
    @(posedge sys_clk);
    ev[k] <= 1'b0;
  endtask : evt
  task automatic wait_msgs(input int n);
    for (int i = 0; i < 80 && msg_count < n; i++) @(posedge sys_clk);
    check("msg_count", n, msg_count);
    if (msg_count != n) report_and_stop();
  endtask : wait_msgs
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge sys_clk);
      link_speed <= rows[i].spd;
      link_width <= rows[i].wid;
      dl_active  <= rows[i].dl;
      cfg_read(8'hD0);
      check("link_row", {2'h0, rows[i].dl, 3'h0, rows[i].wid, rows[i].spd, 16'h0000},
            rd & 32'h23FF_0000);
    end
    @(posedge sys_clk);
    link_speed <= 4'h2;
    link_width <= 6'h01;
    dl_active  <= 1'b0;
    do_reset(1'b1);
    cfg_read(8'hD0);
    check("link_rst", 32'h1812_0000, rd & 32'hFFFF_0020);
    cfg_read(8'hD4);
    check("caps_rst", 32'h0000_0CDF, rd);
    cfg_read(8'h40);
    check("unmapped", 32'h0, rd);
    evt(2);
    cfg_read(8'hD0);
    check("trained", 32'h0, rd & 32'h0C00_0000);
    evt(1);
    evt(0);
    cfg_read(8'hD0);
    check("train_err", 32'h0400_0000, rd & 32'h0C00_0000);
    evt(2);
    cfg_read(8'hD0);
    check("err_clr", 32'h0, rd & 32'h0C00_0000);
    // bandwidth flags: zero writes keep them, each one clears only its own bit
    evt(3);
    evt(4);
    cfg_write(8'hD0, 4'h8, 32'h0);
    cfg_read(8'hD0);
    check("bw_set", 32'hC000_0000, rd & 32'hC000_0000);
    cfg_write(8'hD0, 4'h8, 32'h4000_0000);
    cfg_read(8'hD0);
    check("bw_w1c", 32'h8000_0000, rd & 32'hC000_0000);
    cfg_write(8'hD0, 4'h8, 32'h8000_0000);
    cfg_read(8'hD0);
    check("abw_w1c", 32'h0, rd & 32'hC000_0000);
    // event and write-one clear in one cycle: the event keeps the flag
    fork
      evt(3);
      cfg_write(8'hD0, 4'h8, 32'h4000_0000);
    join
    cfg_read(8'hD0);
    check("bw_race", 32'h4000_0000, rd & 32'hC000_0000);
    cfg_write(8'hD0, 4'h1, 32'h0000_0020);
    #1 check("retrain", 32'h1, {31'h0, retrain});
    cfg_read(8'hD0);
    check("retrain_rd", 32'h0800_0000, rd & 32'h0800_0020);
    evt(2);
    // read-only fields written with other values (slot number ones, flags zeros) must not move
    cfg_write(8'hD4, 4'hF, 32'hFFF9_1500);
    wait_msgs(1);
    check("payload1", 32'h22A, {22'h0, last});
    cfg_read(8'hD4);
    check("caps_wr", 32'h0001_155F, rd);
    @(posedge sys_clk);
    model_delay <= 4'h6;
    cfg_write(8'hD4, 4'h7, 32'h0000_8880);
    cfg_write(8'hD4, 4'h1, 32'h0);
    cfg_write(8'hD4, 4'h4, 32'h0001_0000);
    wait_msgs(3);
    repeat (20) @(posedge sys_clk);
    check("collapse", 32'h3, msg_count);
    check("payload2", 32'h310, {22'h0, last});
    // a load in the cycle of a write wins and sends no message
    fork
      evt(5);
      cfg_write(8'hD4, 4'h7, 32'h0000_0000);
    join
    cfg_read(8'hD4);
    check("caps_ld", 32'h55E0_99AA, rd);
    cfg_read(8'hD0);
    check("clk_ld", 32'h0, rd & 32'h1000_0000);
    repeat (15) @(posedge sys_clk);
    check("ld_nomsg", 32'h3, msg_count);
    do_reset(1'b0);
    cfg_write(8'hD4, 4'h7, 32'h0000_8880);
    cfg_read(8'hD4);
    check("up_caps", 32'h0, rd);
    cfg_write(8'hD0, 4'h1, 32'h0000_0020);
    #1 check("up_retrain", 32'h0, {31'h0, retrain});
    repeat (10) @(posedge sys_clk);
    check("up_msg", 32'h0, msg_count);
    report_and_stop();
  end
endmodule : tb_top
